// >>> logic/ipg_pkg.sv
`default_nettype none
package ipg_pkg;
   // timing, in printed units, and the 200 MHz clock rate
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned PULSE_US = 100;
   localparam int unsigned GAP_US = 100;
   localparam int unsigned REPEAT_MS = 5;
   localparam int unsigned SDM_FILT_US = 64;
   localparam int unsigned PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int unsigned GAP_CYC = GAP_US * CLK_MHZ;
   localparam int unsigned REPEAT_CYC = REPEAT_MS * 1000 * CLK_MHZ;
   localparam int unsigned SDM_FILT_CYC = SDM_FILT_US * CLK_MHZ;
   localparam int unsigned CNT_W = 24;
   // status register widths
   localparam int unsigned SUP_W = 8;
   localparam int unsigned THM_W = 4;
   localparam int unsigned BUS_W = 4;
   localparam int unsigned HSL_W = 9;
   localparam int unsigned DRAIN_SOURCE_OV_REG_W = 9;
   localparam int unsigned DEV_W = 2;
   localparam int unsigned WAKE_W = 3;
   // field positions
   localparam int unsigned SUP_POR = 0;
   localparam int unsigned SUP_UV = 1;
   localparam int unsigned SUP_SC = 2;
   localparam int unsigned SUP_OV = 3;
   localparam int unsigned THM_THERMAL_SHUTDOWN_LEVEL2 = 3;
   localparam int unsigned DRAIN_SOURCE_OV_REG_BRK_LO = 6;
   localparam int unsigned DEV_SPI_FAIL = 0;
   localparam int unsigned DEV_CRC_FAIL = 1;
   localparam int unsigned WAKE_CAN = 0;
   localparam int unsigned WAKE_PIN = 1;
   localparam int unsigned WAKE_TIMER = 2;
   // group flag and clear strobe positions
   localparam int unsigned GRP_SUP = 0;
   localparam int unsigned GRP_THM = 1;
   localparam int unsigned GRP_BUS = 2;
   localparam int unsigned GRP_HS = 3;
   localparam int unsigned GRP_BD = 4;
   localparam int unsigned GRP_SPI = 5;
   localparam int unsigned GRP_W = 6;
   localparam int unsigned CLR_SUP = 0;
   localparam int unsigned CLR_THM = 1;
   localparam int unsigned CLR_BUS = 2;
   localparam int unsigned CLR_HSL = 3;
   localparam int unsigned CLR_DRAIN_SOURCE_OV_REG = 4;
   localparam int unsigned CLR_DEV = 5;
   localparam int unsigned CLR_WAKE = 6;
   localparam int unsigned CLR_W = 7;
   typedef enum logic [2:0] {
      ipg_init, ipg_normal, ipg_stop, ipg_sleep, ipg_restart, ipg_failsafe
   } ipg_mode_e;
   typedef struct packed {
      logic [SUP_W-1:0] sup;
      logic [THM_W-1:0] thm;
      logic [BUS_W-1:0] bus;
      logic [HSL_W-1:0] high_side_load_status;
      logic [DRAIN_SOURCE_OV_REG_W-1:0] drain_source_ov;
      logic [DEV_W-1:0] device_status;
      logic [WAKE_W-1:0] wake_status;
   } ipg_stat_s;
   localparam ipg_stat_s STAT_RST = '0;
   localparam logic SDM_RST = 1'b0;
endpackage
`default_nettype wire

// >>> logic/ipg_top.sv
// Operation
// - pulse low for 100 us in normal/stop
// - keep output high 100 us between pulses
// - interrupts never change the operating mode
// - one mask bit per group gates pulses
// - supply/thermal groups exclude reset-class bits
// - bus, high-side, bridge, serial-fail group flags
// - wake bits interrupt only when configured, except on stop entry
// - wake sources: bus, pin, timer, brake
// - mask and wake paths trigger independently
// - reset-class faults never raise a pulse
// - repeat every 5 ms for serial faults
// - periodic repeat switchable by control bit
// - no pulse in restart, fail-safe, sleep
// - pulse on stop entry with wake pending
// - visible status refreshed at pulse start
// - events stay latched until cleared
// - events during a pulse merge
// - sample pin after 64 us filter in init
`default_nettype none
module ipg_top #(
   parameter int unsigned PULSE_CYC = ipg_pkg::PULSE_CYC,
   parameter int unsigned GAP_CYC = ipg_pkg::GAP_CYC,
   parameter int unsigned REPEAT_CYC = ipg_pkg::REPEAT_CYC,
   parameter int unsigned SDM_FILT_CYC = ipg_pkg::SDM_FILT_CYC
) (
   input wire logic mclk_in, // 200 MHz
   input wire logic rstn_in, // sync reset, low
   input wire ipg_pkg::ipg_mode_e mode_in, // device mode
   input wire ipg_pkg::ipg_stat_s evt_in, // one-cycle set pulses
   input wire logic [ipg_pkg::CLR_W-1:0] clr_in, // per-register clear
   input wire logic [ipg_pkg::GRP_W-1:0] mask_in, // group enables
   input wire logic [ipg_pkg::WAKE_W-1:0] wake_src_in, // wake source config
   input wire logic brake_en_in, // any brake feature on
   input wire logic periodic_irq_enable_in, // repeat pulses on
   input wire logic intn_pin_in, // pin level readback
   output logic intn_n_out, // interrupt, low active
   output logic intn_oe_out, // pin drive enable
   output ipg_pkg::ipg_stat_s stat_out, // visible status
   output logic software_development_mode_out, // strap result
   output logic sdm_valid_out // strap sampled
);
   typedef enum {ipg_idle, ipg_pulse, ipg_gap} ipg_state_e;
   localparam logic [ipg_pkg::CNT_W-1:0] PULSE_TC = ipg_pkg::CNT_W'(PULSE_CYC - 1);
   localparam logic [ipg_pkg::CNT_W-1:0] GAP_TC = ipg_pkg::CNT_W'(GAP_CYC - 1);
   localparam logic [ipg_pkg::CNT_W-1:0] REP_TC = ipg_pkg::CNT_W'(REPEAT_CYC - 1);
   localparam logic [ipg_pkg::CNT_W-1:0] SDM_TC = ipg_pkg::CNT_W'(SDM_FILT_CYC - 1);
   localparam logic [ipg_pkg::CNT_W-1:0] CNT_MAX = '1;

   function automatic ipg_pkg::ipg_stat_s clr_mask(input logic [ipg_pkg::CLR_W-1:0] c);
      clr_mask.sup = {ipg_pkg::SUP_W{c[ipg_pkg::CLR_SUP]}};
      clr_mask.thm = {ipg_pkg::THM_W{c[ipg_pkg::CLR_THM]}};
      clr_mask.bus = {ipg_pkg::BUS_W{c[ipg_pkg::CLR_BUS]}};
      clr_mask.high_side_load_status = {ipg_pkg::HSL_W{c[ipg_pkg::CLR_HSL]}};
      clr_mask.drain_source_ov = {ipg_pkg::DRAIN_SOURCE_OV_REG_W{c[ipg_pkg::CLR_DRAIN_SOURCE_OV_REG]}};
      clr_mask.device_status = {ipg_pkg::DEV_W{c[ipg_pkg::CLR_DEV]}};
      clr_mask.wake_status = {ipg_pkg::WAKE_W{c[ipg_pkg::CLR_WAKE]}};
   endfunction

   function automatic logic [ipg_pkg::GRP_W-1:0] grp(input ipg_pkg::ipg_stat_s s);
      logic [ipg_pkg::SUP_W-1:0] sx;
      logic [ipg_pkg::THM_W-1:0] tx;
      sx = s.sup;
      sx[ipg_pkg::SUP_POR] = 1'b0;
      sx[ipg_pkg::SUP_UV] = 1'b0;
      sx[ipg_pkg::SUP_SC] = 1'b0;
      sx[ipg_pkg::SUP_OV] = 1'b0;
      tx = s.thm;
      tx[ipg_pkg::THM_THERMAL_SHUTDOWN_LEVEL2] = 1'b0;
      grp[ipg_pkg::GRP_SUP] = |sx;
      grp[ipg_pkg::GRP_THM] = |tx;
      grp[ipg_pkg::GRP_BUS] = |s.bus;
      grp[ipg_pkg::GRP_HS] = |s.high_side_load_status;
      grp[ipg_pkg::GRP_BD] = |s.drain_source_ov;
      grp[ipg_pkg::GRP_SPI] = s.device_status[ipg_pkg::DEV_SPI_FAIL] |
                              s.device_status[ipg_pkg::DEV_CRC_FAIL];
   endfunction

   function automatic logic wake_any(input ipg_pkg::ipg_stat_s s,
                                     input logic [ipg_pkg::WAKE_W-1:0] cfg,
                                     input logic brk);
      wake_any = (|(s.wake_status & cfg)) |
                 (brk & (|s.drain_source_ov[ipg_pkg::DRAIN_SOURCE_OV_REG_W-1:ipg_pkg::DRAIN_SOURCE_OV_REG_BRK_LO]));
   endfunction

   ipg_pkg::ipg_stat_s live_reg, live_next, vis_reg, vis_next, fresh, cm;
   ipg_state_e state_reg, state_next;
   ipg_pkg::ipg_mode_e mode_q_reg;
   logic [ipg_pkg::CNT_W-1:0] cnt_reg, cnt_next, rep_reg, sdm_cnt_reg;
   logic pend_reg, intn_n_reg, oe_reg, sdm_reg, sdm_valid_reg, pin_q_reg;
   logic active, blocked, new_evt, stop_entry, rep_pending, rep_due, trig, start;
   logic [ipg_pkg::GRP_W-1:0] grp_fresh, grp_live;

   // the mode is only observed here, never driven
   assign active = (mode_in == ipg_pkg::ipg_normal) || (mode_in == ipg_pkg::ipg_stop);
   assign blocked = !active;
   assign cm = clr_mask(clr_in);
   assign fresh = ipg_pkg::ipg_stat_s'(evt_in & ~live_reg);
   assign grp_fresh = grp(fresh);
   assign grp_live = grp(live_reg);
   // mask path and wake path are independent triggers
   assign new_evt = (|(grp_fresh & mask_in)) |
                    wake_any(fresh, wake_src_in, brake_en_in);
   assign stop_entry = (mode_in == ipg_pkg::ipg_stop) && (mode_q_reg != ipg_pkg::ipg_stop) &&
                       ((|live_reg.wake_status) ||
                        (|live_reg.drain_source_ov[ipg_pkg::DRAIN_SOURCE_OV_REG_W-1:ipg_pkg::DRAIN_SOURCE_OV_REG_BRK_LO]));
   assign rep_pending = periodic_irq_enable_in && mask_in[ipg_pkg::GRP_SPI] &&
                        grp_live[ipg_pkg::GRP_SPI];
   assign rep_due = rep_pending && (rep_reg == REP_TC);
   assign trig = new_evt || stop_entry || rep_due;
   assign start = (state_reg == ipg_idle) && active && pend_reg;

   // sticky status: set wins over clear
   always_comb begin
      live_next = ipg_pkg::ipg_stat_s'((live_reg & ~cm) | evt_in);
      vis_next = ipg_pkg::ipg_stat_s'(vis_reg & ~cm);
      if (start) begin
         vis_next = live_next;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         live_reg <= ipg_pkg::STAT_RST;
         vis_reg <= ipg_pkg::STAT_RST;
      end else begin
         live_reg <= live_next;
         vis_reg <= vis_next;
      end
   end

   // request flag; events while a pulse runs are absorbed
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         pend_reg <= 1'b0;
      end else if (blocked) begin
         pend_reg <= 1'b0;
      end else if (state_reg == ipg_pulse || start) begin
         pend_reg <= 1'b0;
      end else if (trig) begin
         pend_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         mode_q_reg <= ipg_pkg::ipg_init;
      end else begin
         mode_q_reg <= mode_in;
      end
   end

   // pulse / gap sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 1'b1;
      unique case (state_reg)
         ipg_idle: begin
            cnt_next = '0;
            if (start) begin
               state_next = ipg_pulse;
            end
         end
         ipg_pulse: begin
            if (blocked || cnt_reg == PULSE_TC) begin
               state_next = ipg_gap;
               cnt_next = '0;
            end
         end
         ipg_gap: begin
            if (cnt_reg == GAP_TC) begin
               state_next = ipg_idle;
               cnt_next = '0;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         state_reg <= ipg_idle;
         cnt_reg <= '0;
         intn_n_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         intn_n_reg <= (state_next != ipg_pulse);
      end
   end

   // repeat timer restarts at every pulse start
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         rep_reg <= '0;
      end else if (!rep_pending || start || rep_due) begin
         rep_reg <= '0;
      end else begin
         rep_reg <= rep_reg + 1'b1;
      end
   end

   // strap sampling: pin released during init, level must hold for the filter time
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         oe_reg <= 1'b0;
         pin_q_reg <= 1'b0;
         sdm_cnt_reg <= '0;
         sdm_reg <= ipg_pkg::SDM_RST;
         sdm_valid_reg <= 1'b0;
      end else begin
         oe_reg <= (mode_in != ipg_pkg::ipg_init);
         pin_q_reg <= intn_pin_in;
         if (mode_in != ipg_pkg::ipg_init || sdm_valid_reg) begin
            sdm_cnt_reg <= '0;
         end else if (intn_pin_in != pin_q_reg) begin
            sdm_cnt_reg <= '0;
         end else if (sdm_cnt_reg == SDM_TC) begin
            sdm_reg <= pin_q_reg;
            sdm_valid_reg <= 1'b1;
         end else begin
            sdm_cnt_reg <= sdm_cnt_reg + 1'b1;
         end
      end
   end

   assign intn_n_out = intn_n_reg;
   assign intn_oe_out = oe_reg;
   assign stat_out = vis_reg;
   assign software_development_mode_out = sdm_reg;
   assign sdm_valid_out = sdm_valid_reg;

   // helper counters for checking
   logic [ipg_pkg::CNT_W-1:0] lo_cnt_reg, hi_cnt_reg;
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         lo_cnt_reg <= '0;
         hi_cnt_reg <= CNT_MAX;
      end else if (!intn_n_reg) begin
         lo_cnt_reg <= lo_cnt_reg + 1'b1;
         hi_cnt_reg <= '0;
      end else begin
         lo_cnt_reg <= '0;
         hi_cnt_reg <= (hi_cnt_reg == CNT_MAX) ? CNT_MAX : hi_cnt_reg + 1'b1;
      end
   end

   // reset-class bits only: por, uv, sc, ov and thermal level 2
   ipg_pkg::ipg_stat_s excl_sel;
   always_comb begin
      excl_sel = ipg_pkg::STAT_RST;
      excl_sel.sup[ipg_pkg::SUP_POR] = 1'b1;
      excl_sel.sup[ipg_pkg::SUP_UV] = 1'b1;
      excl_sel.sup[ipg_pkg::SUP_SC] = 1'b1;
      excl_sel.sup[ipg_pkg::SUP_OV] = 1'b1;
      excl_sel.thm[ipg_pkg::THM_THERMAL_SHUTDOWN_LEVEL2] = 1'b1;
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_stop_req;
      stop_entry && state_reg == ipg_idle && !pend_reg;
   endsequence
   sequence s_pulse_start;
      $fell(intn_n_out);
   endsequence
   sequence s_rep_req;
      rep_due && state_reg == ipg_idle && !pend_reg && active;
   endsequence
   sequence s_wake_req;
      (|(evt_in.wake_status & ~live_reg.wake_status & wake_src_in)) &&
      state_reg == ipg_idle && !pend_reg && active;
   endsequence
   sequence s_bus_req;
      (|(evt_in.bus & ~live_reg.bus)) && mask_in[ipg_pkg::GRP_BUS] &&
      state_reg == ipg_idle && !pend_reg && active;
   endsequence

   a_pulse_width: assert property ($rose(intn_n_out) && $past(active)
      |-> $past(lo_cnt_reg) == PULSE_TC) else $error("pulse width wrong");
   a_pulse_bound: assert property (!intn_n_out |-> lo_cnt_reg <= PULSE_TC)
      else $error("pulse too long");
   a_gap_min: assert property (s_pulse_start |-> $past(hi_cnt_reg) >= GAP_TC)
      else $error("gap too short");
   a_quiet_blocked: assert property (blocked |=> intn_n_out)
      else $error("pulse in blocked mode");
   a_status_sticky: assert property (1'b1 |=> ($past(live_reg) &
      ~$past(cm) & ~live_reg) == '0) else $error("status bit lost");
   a_snapshot_fall: assert property (s_pulse_start |-> vis_reg == $past(live_next))
      else $error("status not refreshed");
   a_merge_low: assert property (!intn_n_out |-> !pend_reg)
      else $error("event not merged");
   a_stop_entry: assert property (s_stop_req ##1 active |-> ##1 s_pulse_start)
      else $error("no pulse on stop entry");
   a_rep_gate: assert property (!periodic_irq_enable_in |=> rep_reg == '0)
      else $error("repeat timer running");
   a_sdm_filter: assert property ($rose(sdm_valid_out) |-> $past(sdm_cnt_reg) == SDM_TC)
      else $error("strap sampled early");
   a_sdm_hold: assert property (sdm_valid_out |=> sdm_valid_out &&
      $stable(software_development_mode_out)) else $error("strap result changed");
   a_oe_level: assert property (1'b1 |=>
      intn_oe_out == ($past(mode_in) != ipg_pkg::ipg_init)) else $error("pin drive wrong");

   // mode gating and reset-class exclusion
   a_start_active: assert property (s_pulse_start |-> $past(active))
      else $error("pulse started while blocked");
   a_pend_blocked: assert property (blocked |=> !pend_reg)
      else $error("request kept while blocked");
   a_reset_class: assert property ((evt_in & ~excl_sel) == '0 && !pend_reg &&
      !stop_entry && !rep_due |=> !pend_reg) else $error("reset-class bit raised a request");

   // request-to-pulse paths
   a_pulse_merge: assert property (state_reg == ipg_pulse |=> !pend_reg)
      else $error("request kept during pulse");
   a_rep_trigger: assert property (s_rep_req ##1 active |-> ##1 s_pulse_start)
      else $error("no repeat pulse");
   a_rep_bound: assert property (rep_reg <= REP_TC)
      else $error("repeat timer overran");
   a_wake_trigger: assert property (s_wake_req ##1 active |-> ##1 s_pulse_start)
      else $error("no pulse on wake event");
   a_bus_trigger: assert property (s_bus_req ##1 active |-> ##1 s_pulse_start)
      else $error("no pulse on enabled group");

   // status snapshot and clearing
   a_status_hold: assert property (!start && clr_in == '0 |=> $stable(stat_out))
      else $error("status changed between pulses");
   a_wake_clear: assert property (clr_in[ipg_pkg::CLR_WAKE] && evt_in.wake_status == '0
      |=> stat_out.wake_status == '0) else $error("wake status not cleared");
   a_sup_clear: assert property (clr_in[ipg_pkg::CLR_SUP] && evt_in.sup == '0
      |=> live_reg.sup == '0) else $error("supply status not cleared");

   // sequencer output and counters
   a_pulse_low: assert property (state_reg == ipg_pulse |-> !intn_n_out)
      else $error("output high during pulse");
   a_gap_high: assert property (state_reg == ipg_gap |-> intn_n_out)
      else $error("output low during gap");
   a_gap_count: assert property (state_reg == ipg_gap |-> cnt_reg <= GAP_TC)
      else $error("gap counter overran");
   a_idle_count: assert property (state_reg == ipg_idle |-> cnt_reg == '0)
      else $error("counter not parked");
endmodule
`default_nettype wire

// >>> verification/ipg_host.sv
`default_nettype none
module ipg_host (
   input wire logic mclk_in, // device clock
   input wire logic intn_n_in, // interrupt from device
   input wire logic intn_oe_in, // device drives pin
   output logic pin_out, // resolved pin level
   output int pulses_out, // pulses seen
   output int width_out, // last low width
   output int gap_out // shortest high time between pulses
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   int wid = 0;
   int gap = 1000000;
   int low_cnt = 0;
   int high_cnt = 0;
   // pin has a pull-up while the device does not drive it
   assign pin_out = intn_oe_in ? intn_n_in : 1'b1;
   assign pulses_out = cnt;
   assign width_out = wid;
   assign gap_out = gap;
   always @(posedge mclk_in) begin
      if (pin_out === 1'b0) begin
         if (low_cnt == 0) begin
            cnt <= cnt + 1;
            if (cnt > 0 && high_cnt < gap) gap <= high_cnt;
         end
         low_cnt <= low_cnt + 1;
         high_cnt <= 0;
      end else begin
         if (low_cnt != 0) wid <= low_cnt;
         low_cnt <= 0;
         high_cnt <= high_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int P = 8;
   localparam int G = 8;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   ipg_pkg::ipg_mode_e mode = ipg_pkg::ipg_init;
   ipg_pkg::ipg_stat_s evt = '0;
   logic [6:0] clr = '0;
   logic [5:0] mask = '0;
   logic [2:0] wsrc = '0;
   logic brk = 1'b0;
   logic cyc = 1'b0;
   logic pin, intn_n, oe, software_development_mode, sdm_v;
   ipg_pkg::ipg_stat_s stat;
   int pulses, width, gap;
   int miscompares = 0;
   int samples_checked = 0;
   int seed = 32'had35;
   ipg_top #(.PULSE_CYC(P), .GAP_CYC(G), .REPEAT_CYC(64), .SDM_FILT_CYC(8)) uut (
      .mclk_in(mclk), .rstn_in(rstn), .mode_in(mode), .evt_in(evt), .clr_in(clr),
      .mask_in(mask), .wake_src_in(wsrc), .brake_en_in(brk), .periodic_irq_enable_in(cyc),
      .intn_pin_in(pin), .intn_n_out(intn_n), .intn_oe_out(oe), .stat_out(stat),
      .software_development_mode_out(software_development_mode), .sdm_valid_out(sdm_v));
   ipg_host host (.mclk_in(mclk), .intn_n_in(intn_n), .intn_oe_in(oe), .pin_out(pin),
      .pulses_out(pulses), .width_out(width), .gap_out(gap));
   initial forever #2.5 mclk = ~mclk;
   task automatic results();
      $display("checked %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [38:0] got, input logic [38:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic fire(input int b);
      @(negedge mclk);
      evt[b] = 1'b1;
      @(negedge mclk);
      evt = '0;
   endtask
   function automatic int clr_of(input int b);
      return b >= 31 ? 0 : b >= 27 ? 1 : b >= 23 ? 2 : b >= 14 ? 3 : b >= 5 ? 4 : b >= 3 ? 5 : 6;
   endfunction
   // expected pulse for one fresh status bit under the present configuration
   function automatic int model(input int b);
      if (mode != ipg_pkg::ipg_normal && mode != ipg_pkg::ipg_stop) return 0;
      if (b >= 31) return int'(b > 34 && mask[0]);
      if (b >= 27) return int'(b < 30 && mask[1]);
      if (b >= 23) return int'(mask[2]);
      if (b >= 14) return int'(mask[3]);
      if (b >= 5) return int'(mask[4] || (b >= 11 && brk));
      if (b >= 3) return int'(mask[5]);
      return int'(wsrc[b]);
   endfunction
   task automatic trial(input int b, input int w);
      int n0;
      int e;
      n0 = pulses;
      e = model(b);
      if (e == 1 && cyc && b >= 3 && b < 5) e = 1 + (w - 3) / 64;
      fire(b);
      cycles(w);
      chk(pulses - n0, e);
      if (e > 0) begin
         chk(stat[b], 1);
         chk(width, P);
      end
      clr[clr_of(b)] = 1'b1;
      @(negedge mclk);
      clr = '0;
      cycles(2);
      chk(stat, '0);
      cycles(1);
      chk(stat, '0);
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      results();
   end
   initial begin
      int b;
      ipg_pkg::ipg_mode_e ml[4];
      ml = '{ipg_pkg::ipg_sleep, ipg_pkg::ipg_restart, ipg_pkg::ipg_failsafe, ipg_pkg::ipg_stop};
      cycles(20);
      chk(intn_n, 1);
      chk(stat, '0);
      rstn = 1'b1;
      for (b = 0; b < 50 && sdm_v !== 1'b1; b++) cycles(1);
      if (b == 50) begin
         miscompares++;
         results();
      end
      chk(software_development_mode, 1);
      chk(oe, 0);
      mode = ipg_pkg::ipg_normal;
      cycles(3);
      chk(oe, 1);
      $display("test strap done");
      for (int pass = 0; pass < 2; pass++) begin
         mask = pass ? 6'h3f : 6'($random(seed));
         wsrc = pass ? 3'h7 : 3'($random(seed));
         brk = pass ? 1'b1 : 1'($random(seed));
         for (b = 0; b < 39; b++) trial(b, 30);
      end
      $display("test sources done");
      foreach (ml[i]) begin
         mode = ml[i];
         trial(23, 30);
         mode = ipg_pkg::ipg_normal;
      end
      $display("test modes done");
      cyc = 1'b1;
      trial(3, 160);
      trial(4, 160);
      trial(35, 160);
      cyc = 1'b0;
      trial(3, 160);
      $display("test repeat done");
      b = pulses;
      fire(23);
      cycles(3);
      fire(27);
      cycles(40);
      chk(pulses - b, 1);
      fire(14);
      cycles(9);
      fire(5);
      cycles(40);
      chk(pulses - b, 3);
      chk(gap >= G, 1);
      clr = 7'h7f;
      cycles(1);
      clr = '0;
      $display("test merge done");
      mask = '0;
      b = pulses;
      fire(1);
      cycles(30);
      mode = ipg_pkg::ipg_stop;
      cycles(30);
      chk(pulses - b, 2);
      chk(stat[1], 1);
      $display("test stop entry done");
      results();
   end
endmodule
`default_nettype wire
